// [dfr_dest_regs.sv]
// Destination entry register set: queue of submitted transfers, write progress and APB access
// Functional notes
// - Chaining enable bit 22: completion raises chain event only when set
// - Interrupt enable bit 20: completion raises completion interrupt only when set; code gates only interrupt_pending_set, irq ignores the bit
// - Six-bit code in bits 17..12 selects pending bit on completion
// - Width select bits 10..8: 8 to 256 bits, codes 6 and 7 reserved
// - Width setting matters only when an address mode is constant
// - Priority bits 6..4, zero highest, seven lowest
// - Bit 1: destination offset increments, or wraps at width when constant
// - Bit 0: source offset increments, or wraps at width when constant
// - Upper count half holds remaining number of arrays
// - Lower count half holds remaining bytes of current array
// - Both counts update as writes issue, showing data still to write
// - One entry per index from zero up to the depth
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module dfr_dest_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        submit_valid,
   input  wire logic [31:0] submit_options,
   input  wire logic [31:0] submit_counts,
   output logic             submit_ready,
   input  wire logic        wr_issue,
   input  wire logic [15:0] wr_bytes,
   output logic      [15:0] dst_offset,
   output logic      [15:0] src_offset,
   output logic      [2:0]  active_priority,
   output logic             active_valid,
   output logic             chain_event_set,
   output logic             interrupt_pending_set,
   output logic      [5:0]  completion_code,
   output logic             irq
);

   dfr_pkg::dfr_state_s q;
   dfr_pkg::dfr_state_s d;

   // Entry decode, shared by the read and the write paths
   function automatic logic entry_hit(input logic [11:0] a);
      entry_hit = (a[11:8] == dfr_pkg::ENTRY_PAGE) && (a[7:4] < 4'(dfr_pkg::NUM_ENTRIES));
   endfunction

   // Byte mask of one width unit; reserved codes fall back to the narrowest unit
   function automatic logic [15:0] width_mask(input logic [2:0] fifo_width_select);
      logic [15:0] m;
      m = dfr_pkg::ZERO16;
      if (fifo_width_select <= dfr_pkg::FIFO_WIDTH_SELECT_MAX_LEGAL) begin
         m = (dfr_pkg::ONE16 << fifo_width_select) - dfr_pkg::ONE16;
      end
      width_mask = m;
   endfunction

   // Next offset in one array: constant mode wraps inside the width unit
   function automatic logic [15:0] next_off(input logic [15:0] off, input logic [15:0] nb,
                                            input logic mode, input logic [2:0] fifo_width_select);
      logic [15:0] s;
      s = off + nb;
      if (mode == dfr_pkg::MODE_CONSTANT) begin
         next_off = s & width_mask(fifo_width_select);
      end else begin
         next_off = s;
      end
   endfunction

   // Read mux for the APB slave; source address always reads zero
   function automatic logic [31:0] read_word(input dfr_pkg::dfr_state_s s, input logic [11:0] a);
      logic [31:0] r;
      logic [1:0]  i;
      r = dfr_pkg::RESET_WORD;
      i = a[5:4];
      if (entry_hit(a)) begin
         case (a[3:0])
            dfr_pkg::ENT_OPTIONS:  r = s.ent[i].options;
            dfr_pkg::ENT_COUNTS:   r = {s.ent[i].arr_cnt, s.ent[i].byte_cnt};
            default:               r = dfr_pkg::RESET_WORD;
         endcase
      end else if (a == dfr_pkg::ADDR_IRQ_STATUS) begin
         r = {{(32-dfr_pkg::EV_W){1'b0}}, s.sts};
      end else if (a == dfr_pkg::ADDR_IRQ_ENABLE) begin
         r = {{(32-dfr_pkg::EV_W){1'b0}}, s.ien};
      end
      read_word = r;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      logic e;
      e = entry_hit(a) && (a[3:0] == dfr_pkg::ENT_OPTIONS || a[3:0] == dfr_pkg::ENT_SRC_ADDR
                           || a[3:0] == dfr_pkg::ENT_COUNTS);
      mapped = e || a == dfr_pkg::ADDR_SA_DEST_BREF || a == dfr_pkg::ADDR_IRQ_STATUS
               || a == dfr_pkg::ADDR_IRQ_CLEAR || a == dfr_pkg::ADDR_IRQ_ENABLE;
   endfunction

   // Occupancy step of one push or one pop
   function automatic logic [dfr_pkg::OCC_W-1:0] occ_inc(input logic b);
      occ_inc = {{(dfr_pkg::OCC_W-1){1'b0}}, b};
   endfunction

   // Next-state logic for the whole block
   always_comb begin
      logic [31:0]           hopt;
      logic [15:0]           nb;
      logic [15:0]           left;
      logic                  apb_wr;
      logic                  pop;
      logic                  push;
      logic [dfr_pkg::EV_W-1:0] ev;
      logic [dfr_pkg::EV_W-1:0] clr;
      logic [1:0]            wi;
      hopt   = q.ent[q.rd_ptr].options;
      nb     = dfr_pkg::ZERO16;
      left   = dfr_pkg::ZERO16;
      pop    = 1'b0;
      ev     = '0;
      clr    = '0;
      wi     = paddr[5:4];
      d      = q;
      apb_wr = psel && penable && q.pready && pwrite;
      push   = submit_valid && q.sub_ready;

      // APB setup cycle prepares a one-cycle answer in the access phase
      d.pready  = psel && !penable;
      d.pslverr = psel && !penable && !mapped(paddr);
      d.prdata  = (psel && !penable && !pwrite) ? read_word(q, paddr) : dfr_pkg::RESET_WORD;

      // Software writes: writable option fields, enable and clear registers
      if (apb_wr && entry_hit(paddr) && paddr[3:0] == dfr_pkg::ENT_OPTIONS) begin
         d.ent[wi].options = pwdata & dfr_pkg::OPT_WR_MASK;
      end
      if (apb_wr && paddr == dfr_pkg::ADDR_IRQ_ENABLE) begin
         d.ien = pwdata[dfr_pkg::EV_W-1:0];
      end
      if (apb_wr && paddr == dfr_pkg::ADDR_IRQ_CLEAR) begin
         clr = pwdata[dfr_pkg::EV_W-1:0];
      end

      // Write progress on the head entry
      d.chain_set = 1'b0;
      d.irq_set   = 1'b0;
      if (wr_issue && q.occ != '0) begin
         left = q.ent[q.rd_ptr].byte_cnt;
         nb   = (wr_bytes < left) ? wr_bytes : left;
         d.ent[q.rd_ptr].byte_cnt = left - nb;
         d.dst_off = next_off(q.dst_off, nb, hopt[dfr_pkg::OPT_DAM_BIT],
                              hopt[dfr_pkg::OPT_FIFO_WIDTH_SELECT_HI:dfr_pkg::OPT_FIFO_WIDTH_SELECT_LO]);
         d.src_off = next_off(q.src_off, nb, hopt[dfr_pkg::OPT_SAM_BIT],
                              hopt[dfr_pkg::OPT_FIFO_WIDTH_SELECT_HI:dfr_pkg::OPT_FIFO_WIDTH_SELECT_LO]);
         if ((hopt[dfr_pkg::OPT_DAM_BIT] || hopt[dfr_pkg::OPT_SAM_BIT])
             && hopt[dfr_pkg::OPT_FIFO_WIDTH_SELECT_HI:dfr_pkg::OPT_FIFO_WIDTH_SELECT_LO] > dfr_pkg::FIFO_WIDTH_SELECT_MAX_LEGAL) begin
            ev[dfr_pkg::EV_BAD_WIDTH] = 1'b1;
         end
         if (left == nb) begin
            // Array finished: start the next one at offset zero, or complete
            d.dst_off = dfr_pkg::ZERO16;
            d.src_off = dfr_pkg::ZERO16;
            if (q.ent[q.rd_ptr].arr_cnt <= dfr_pkg::ONE16) begin
               d.ent[q.rd_ptr].arr_cnt = dfr_pkg::ZERO16;
               pop = 1'b1;
               ev[dfr_pkg::EV_COMPLETE] = 1'b1;
               d.done_code = hopt[dfr_pkg::OPT_CODE_HI:dfr_pkg::OPT_CODE_LO];
               d.chain_set = hopt[dfr_pkg::OPT_CHAIN_EN_BIT];
               d.irq_set   = hopt[dfr_pkg::OPT_IRQ_EN_BIT];
            end else begin
               d.ent[q.rd_ptr].arr_cnt  = q.ent[q.rd_ptr].arr_cnt - dfr_pkg::ONE16;
               d.ent[q.rd_ptr].byte_cnt = q.ent[q.rd_ptr].byte_reload;
            end
         end
      end

      // New transfer request fills the tail entry; it wins over a software option write
      if (push) begin
         d.ent[q.wr_ptr].options     = submit_options & dfr_pkg::OPT_WR_MASK;
         d.ent[q.wr_ptr].arr_cnt     = submit_counts[dfr_pkg::CNT_ARR_HI:dfr_pkg::CNT_ARR_LO];
         d.ent[q.wr_ptr].byte_cnt    = submit_counts[dfr_pkg::CNT_BYTE_HI:dfr_pkg::CNT_BYTE_LO];
         d.ent[q.wr_ptr].byte_reload = submit_counts[dfr_pkg::CNT_BYTE_HI:dfr_pkg::CNT_BYTE_LO];
         d.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (pop) begin
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
      d.occ = q.occ + occ_inc(push) - occ_inc(pop);

      // Ready is registered, so it is computed from the next occupancy
      d.sub_ready = d.occ < 3'(dfr_pkg::NUM_ENTRIES);
      d.act_valid = d.occ != '0;
      d.act_pri   = d.ent[d.rd_ptr].options[dfr_pkg::OPT_PRI_HI:dfr_pkg::OPT_PRI_LO];

      // Sticky status: an event in the clear cycle survives
      d.sts = (q.sts & ~clr) | ev;
      d.irq = |(d.sts & d.ien);
   end

   // Single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q           <= '0;
         q.sub_ready <= 1'b1; // Queue is empty out of reset
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign prdata                = q.prdata;
   assign pready                = q.pready;
   assign pslverr               = q.pslverr;
   assign submit_ready          = q.sub_ready;
   assign dst_offset            = q.dst_off;
   assign src_offset            = q.src_off;
   assign active_priority       = q.act_pri;
   assign active_valid          = q.act_valid;
   assign chain_event_set       = q.chain_set;
   assign interrupt_pending_set = q.irq_set;
   assign completion_code       = q.done_code;
   assign irq                   = q.irq;

endmodule

// [dfr_pkg.sv]
// Constants, field layouts and register map of the destination entry register set
package dfr_pkg;
   // Entry replication: indices 0 up to the destination depth inclusive
   localparam int unsigned DEST_ENTRY_DEPTH = 3;
   localparam int unsigned NUM_ENTRIES      = DEST_ENTRY_DEPTH + 1;
   localparam int unsigned PTR_W            = 2;
   localparam int unsigned OCC_W            = 3;

   // Options register field positions
   localparam int unsigned OPT_CHAIN_EN_BIT = 22;
   localparam int unsigned OPT_IRQ_EN_BIT   = 20;
   localparam int unsigned OPT_CODE_HI      = 17;
   localparam int unsigned OPT_CODE_LO      = 12;
   localparam int unsigned OPT_FIFO_WIDTH_SELECT_HI      = 10;
   localparam int unsigned OPT_FIFO_WIDTH_SELECT_LO      = 8;
   localparam int unsigned OPT_PRI_HI       = 6;
   localparam int unsigned OPT_PRI_LO       = 4;
   localparam int unsigned OPT_DAM_BIT      = 1;
   localparam int unsigned OPT_SAM_BIT      = 0;
   localparam logic [31:0] OPT_WR_MASK      = 32'h0053_F773;

   // Counts register layout
   localparam int unsigned CNT_ARR_HI  = 31;
   localparam int unsigned CNT_ARR_LO  = 16;
   localparam int unsigned CNT_BYTE_HI = 15;
   localparam int unsigned CNT_BYTE_LO = 0;

   // Width select encodings
   localparam logic [2:0] FIFO_WIDTH_SELECT_MAX_LEGAL = 3'h5;

   // Address mode encoding
   localparam logic MODE_INCREMENT = 1'b0;
   localparam logic MODE_CONSTANT  = 1'b1;

   // Register map, byte addresses
   localparam logic [11:0] ADDR_SA_DEST_BREF = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h010;
   localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h014;
   localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h018;
   localparam logic [3:0]  ENTRY_PAGE        = 4'h1;
   localparam logic [3:0]  ENT_OPTIONS       = 4'h0;
   localparam logic [3:0]  ENT_SRC_ADDR      = 4'h4;
   localparam logic [3:0]  ENT_COUNTS        = 4'h8;

   // Interrupt status bits
   localparam int unsigned EV_W          = 2;
   localparam int unsigned EV_COMPLETE   = 0;
   localparam int unsigned EV_BAD_WIDTH  = 1;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [15:0] ONE16      = 16'h0001;

   typedef struct packed {
      logic [31:0] options;
      logic [15:0] arr_cnt;
      logic [15:0] byte_cnt;
      logic [15:0] byte_reload;
   } dfr_entry_s;

   typedef struct packed {
      dfr_entry_s [NUM_ENTRIES-1:0] ent;
      logic [PTR_W-1:0]             rd_ptr;
      logic [PTR_W-1:0]             wr_ptr;
      logic [OCC_W-1:0]             occ;
      logic [15:0]                  dst_off;
      logic [15:0]                  src_off;
      logic [EV_W-1:0]              sts;
      logic [EV_W-1:0]              ien;
      logic                         irq;
      logic                         chain_set;
      logic                         irq_set;
      logic [5:0]                   done_code;
      logic [2:0]                   act_pri;
      logic                         act_valid;
      logic                         sub_ready;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
   } dfr_state_s;
endpackage

// [dfr_dest_regs_sva.sv]
// Assertion checker for the destination entry register set
`timescale 1ns/1ns
module dfr_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        submit_valid,
   input wire logic [31:0] submit_options,
   input wire logic        submit_ready,
   input wire logic        wr_issue,
   input wire logic [2:0]  active_priority,
   input wire logic        active_valid,
   input wire logic        chain_event_set,
   input wire logic        interrupt_pending_set
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answers in the single access cycle after setup
   a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
   // Completion pulses only follow a write on a non-empty queue
   a_chain_cause: assert property (
      chain_event_set |-> $past(wr_issue && active_valid)) else $error("chain pulse without write");
   a_irq_cause: assert property (
      interrupt_pending_set |-> $past(wr_issue && active_valid)) else $error("pending pulse without write");
   a_head_prio: assert property (!active_valid && submit_valid && submit_ready |=>
      active_valid && active_priority == $past(submit_options[6:4])) else $error("head priority wrong");
   a_empty_idle: assert property (!active_valid && wr_issue |=>
      !chain_event_set && !interrupt_pending_set) else $error("write on empty queue acted");
   a_full_busy: assert property (!submit_ready |-> active_valid) else $error("full but empty");
   c_chain: cover property (chain_event_set);
   c_full: cover property (!submit_ready);
   c_err: cover property (pslverr);
endmodule
bind dfr_dest_regs dfr_sva dfr_sva_inst (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
   .submit_valid, .submit_options, .submit_ready, .wr_issue, .active_priority, .active_valid,
   .chain_event_set, .interrupt_pending_set);

// [dfr_chan_model.sv]
// Channel-side model: submits transfer requests and issues destination writes
`timescale 1ns/1ns
module dfr_chan_model (
   input  wire logic        pclk,
   output logic             submit_valid,
   output logic      [31:0] submit_options,
   output logic      [31:0] submit_counts,
   output logic             wr_issue,
   output logic      [15:0] wr_bytes
);
   initial begin
      submit_valid = 1'b0;
      wr_issue = 1'b0;
   end
   // Released fields carry the inverse so stale values never look valid
   task automatic submit(input logic [31:0] o, input logic [31:0] c);
      @(posedge pclk);
      submit_valid   <= 1'b1;
      submit_options <= o;
      submit_counts  <= c;
      @(posedge pclk);
      submit_valid   <= 1'b0;
      submit_options <= ~o;
      submit_counts  <= ~c;
   endtask
   task automatic issue(input logic [15:0] b);
      @(posedge pclk);
      wr_issue <= 1'b1;
      wr_bytes <= b;
      @(posedge pclk);
      wr_issue <= 1'b0;
      wr_bytes <= ~b;
   endtask
endmodule

// [dfr_dest_regs_test.sv]
// Self-checking testbench of the destination entry register set
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module dfr_dest_regs_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, submit_valid, submit_ready, wr_issue;
   logic active_valid, chain_event_set, interrupt_pending_set, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, submit_options, submit_counts, rd, o;
   logic [15:0] wr_bytes, dst_offset, src_offset;
   logic [2:0]  active_priority;
   logic [5:0]  completion_code;
   int errors, n_tests, cyc, nxt;
   logic [47:0] ofs [4] = '{48'h0202_0002_0006, 48'h0101_0006_0000, 48'h0200_0006_0006, 48'h0003_0000_0000};
   dfr_dest_regs dfr_dest_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .submit_valid, .submit_options, .submit_counts, .submit_ready, .wr_issue, .wr_bytes,
      .dst_offset, .src_offset, .active_priority, .active_valid, .chain_event_set, .interrupt_pending_set,
      .completion_code, .irq);
   dfr_chan_model dfr_chan_model_inst (.pclk, .submit_valid, .submit_options, .submit_counts, .wr_issue,
      .wr_bytes);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Hang guard, sized well above the planned run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Request held until the edge where ready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic got;
      got = 1'b0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready, read data and error are all taken at the rising edge that sees ready high
      while (!got) begin
         @(posedge pclk);
         got = (pready === 1'b1);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(n, e, rd)
   endtask
   function automatic logic [11:0] ea(input int n, input logic [3:0] r);
      return {dfr_pkg::ENTRY_PAGE, 4'(n % 4), r};
   endfunction
   task automatic sub(input logic [31:0] op, input logic [31:0] c);
      dfr_chan_model_inst.submit(op, c);
      nxt++;
   endtask
   task automatic go(input logic [15:0] b);
      dfr_chan_model_inst.issue(b);
      #1;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc("opt0", ea(0, dfr_pkg::ENT_OPTIONS), 32'h0);
      rdc("cnt3", ea(3, dfr_pkg::ENT_COUNTS), 32'h0);
      rdc("bref", dfr_pkg::ADDR_SA_DEST_BREF, 32'h0);
      apb(1'b0, 12'hFFC, 32'h0);
      `CHK("slverr", 1'b1, er)
      $display("test reset done");
      apb(1'b1, ea(3, dfr_pkg::ENT_OPTIONS), 32'hFFFF_FFFF);
      rdc("optmask", ea(3, dfr_pkg::ENT_OPTIONS), 32'h0053_F773);
      sub(32'h0, 32'h0002_0004);
      rdc("cnt", ea(0, dfr_pkg::ENT_COUNTS), 32'h0002_0004);
      apb(1'b1, ea(0, dfr_pkg::ENT_COUNTS), 32'hFFFF_FFFF);
      rdc("cntro", ea(0, dfr_pkg::ENT_COUNTS), 32'h0002_0004);
      rdc("src", ea(0, dfr_pkg::ENT_SRC_ADDR), 32'h0);
      go(16'h3);
      rdc("left1", ea(0, dfr_pkg::ENT_COUNTS), 32'h0002_0001);
      go(16'h4);
      rdc("left2", ea(0, dfr_pkg::ENT_COUNTS), 32'h0001_0004);
      go(16'h4);
      `CHK("nochain", 1'b0, chain_event_set)
      $display("test counts done");
      // Every chain and interrupt enable combination, distinct codes
      for (int k = 0; k < 4; k++) begin
         o = (32'(k / 2) << 22) | (32'(k % 2) << 20) | (32'(k * 21) << 12);
         sub(o, 32'h0001_0002);
         go(16'h2);
         `CHK("chain", 1'(k / 2), chain_event_set)
         `CHK("pend", 1'(k % 2), interrupt_pending_set)
         `CHK("code", 6'(k * 21), completion_code)
      end
      $display("test completion done");
      for (int n = 0; n < 4; n++) sub(32'(7 - n) << 4, 32'h0001_0001);
      #1;
      `CHK("full", 1'b0, submit_ready)
      for (int n = 0; n < 4; n++) rdc("ent", ea(nxt - 4 + n, dfr_pkg::ENT_OPTIONS), 32'(7 - n) << 4);
      for (int n = 0; n < 4; n++) begin
         `CHK("prio", 3'(7 - n), active_priority)
         go(16'h1);
      end
      `CHK("empty", 1'b0, active_valid)
      go(16'h1);
      `CHK("idlewr", 1'b0, chain_event_set | interrupt_pending_set)
      `CHK("idlev", 1'b0, active_valid)
      $display("test depth done");
      // Offset per address mode and width after two 3-byte writes
      for (int k = 0; k < 4; k++) begin
         sub(32'(ofs[k][47:32]), 32'h0001_0010);
         go(16'h3);
         go(16'h3);
         `CHK("dst", ofs[k][31:16], dst_offset)
         `CHK("src", ofs[k][15:0], src_offset)
         go(16'hA);
      end
      $display("test offsets done");
      apb(1'b1, dfr_pkg::ADDR_IRQ_CLEAR, 32'h3);
      apb(1'b1, dfr_pkg::ADDR_IRQ_ENABLE, 32'h1);
      rdc("ien", dfr_pkg::ADDR_IRQ_ENABLE, 32'h1);
      `CHK("irqoff", 1'b0, irq)
      sub(32'h0, 32'h0001_0001);
      go(16'h1);
      rdc("sts", dfr_pkg::ADDR_IRQ_STATUS, 32'h1);
      `CHK("irqon", 1'b1, irq)
      apb(1'b1, dfr_pkg::ADDR_IRQ_CLEAR, 32'h1);
      rdc("clr", dfr_pkg::ADDR_IRQ_STATUS, 32'h0);
      `CHK("irqclr", 1'b0, irq)
      apb(1'b1, dfr_pkg::ADDR_IRQ_CLEAR, 32'h1);
      sub(32'h0000_0601, 32'h0001_0002);
      go(16'h2);
      apb(1'b1, dfr_pkg::ADDR_IRQ_CLEAR, 32'h1);
      rdc("badw", dfr_pkg::ADDR_IRQ_STATUS, 32'h2);
      `CHK("irqmask", 1'b0, irq)
      $display("test interrupts done");
      end_of_test();
   end
endmodule
